// ---- bench/adc_ctrl_props.sv ----
`timescale 1ns/1ps
module adc_ctrl_props (
	input wire logic             ref_clk,
	input wire logic             rst_n,
	input wire logic [7:0]       sfrAddr,
	input wire logic             sfrWrEn,
	input wire logic [7:0]       sfrWrData,
	input wire logic             convTick,
	input wire logic [2:0]       gainSel,
	input wire logic             bufEnable,
	input wire logic             refIntOn,
	input wire logic             refHigh,
	input wire logic             refExternal,
	input wire logic             trimSign,
	input wire logic [6:0]       trimMag,
	input wire logic             calBusy,
	input wire logic             calSysInput,
	input wire logic             readyFlag,
	input wire logic [3:0][15:0] dacTap,
	input wire logic [3:0]       dacRefSupply
);
	logic [4:0] convCnt_q;
	wire        wrSetup = sfrWrEn && sfrAddr == adc_ctrl_pkg::ADDR_SETUP;
	wire        wrCal   = sfrWrEn && sfrAddr == adc_ctrl_pkg::ADDR_CALFILT;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Ticks seen while one calibration runs
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !calBusy)
			convCnt_q <= 5'h00;
		else if (convTick)
			convCnt_q <= convCnt_q + 5'h01;
	end
	property p_gain;
		wrSetup |=> gainSel == $past(sfrWrData[2:0]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain select wrong");
	property p_buf;
		wrSetup |=> bufEnable == $past(sfrWrData[3]);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer enable wrong");
	property p_ref_level;
		wrSetup |=> {refExternal, refHigh, refIntOn} == $past(sfrWrData[6:4]);
	endproperty
	a_ref_level: assert property (p_ref_level) else $error("reference bits wrong");
	property p_ref_reset;
		$rose(rst_n) |-> refIntOn && refHigh && !refExternal;
	endproperty
	a_ref_reset: assert property (p_ref_reset) else $error("reference reset wrong");
	property p_trim;
		sfrWrEn && sfrAddr == adc_ctrl_pkg::ADDR_TRIM |=> {trimSign, trimMag} == $past(sfrWrData);
	endproperty
	a_trim: assert property (p_trim) else $error("trim fields wrong");
	property p_cal_start;
		wrCal && sfrWrData[2:0] inside {[3'h1:3'h5]} |=> calBusy && calSysInput == $past(sfrWrData[2]);
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration not started");
	property p_cal_len;
		$fell(calBusy) |-> convCnt_q == 5'h07 || convCnt_q == 5'h0E;
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
	property p_cal_ready;
		$fell(calBusy) |-> readyFlag;
	endproperty
	a_cal_ready: assert property (p_cal_ready) else $error("ready flag missing");
	property p_dac;
		sfrWrEn && sfrAddr == adc_ctrl_pkg::ADDR_DAC_BASE + 8'h01
			|=> dacTap[0][15:8] == $past(sfrWrData) && $stable(dacTap[3:1]);
	endproperty
	a_dac: assert property (p_dac) else $error("dac update wrong");
	property p_dac_ref;
		sfrWrEn && sfrAddr == adc_ctrl_pkg::ADDR_DAC_REF |=> dacRefSupply == $past(sfrWrData[3:0]);
	endproperty
	a_dac_ref: assert property (p_dac_ref) else $error("dac reference wrong");
endmodule : adc_ctrl_props

// ---- bench/adc_ctrl_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin numErrors++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module adc_ctrl_tb;
	logic             ref_clk, rst_n, sfrWrEn, sfrRdEn, channelChange;
	logic [7:0]       sfrAddr, sfrWrData, sfrRdData, rdVal;
	logic [23:0]      filterSample, resultData, offsetCoef, gainCoef;
	logic [2:0]       gainSel;
	logic [1:0]       filterSel;
	logic [6:0]       trimMag;
	logic [3:0]       dacRefSupply;
	logic [3:0][15:0] dacTap;
	logic             bufEnable, refIntOn, refHigh, refExternal, trimSign, aclkTick, modTick;
	logic             convTick, discardConv, calBusy, calSysInput, readyFlag, resultValid;
	int               numErrors, numChecks;
	adc_ctrl adc_ctrl_inst (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.sfrAddr       (sfrAddr),
		.sfrWrEn       (sfrWrEn),
		.sfrRdEn       (sfrRdEn),
		.sfrWrData     (sfrWrData),
		.sfrRdData     (sfrRdData),
		.channelChange (channelChange),
		.filterSample  (filterSample),
		.gainSel       (gainSel),
		.bufEnable     (bufEnable),
		.refIntOn      (refIntOn),
		.refHigh       (refHigh),
		.refExternal   (refExternal),
		.trimSign      (trimSign),
		.trimMag       (trimMag),
		.aclkTick      (aclkTick),
		.modTick       (modTick),
		.convTick      (convTick),
		.filterSel     (filterSel),
		.discardConv   (discardConv),
		.calBusy       (calBusy),
		.calSysInput   (calSysInput),
		.readyFlag     (readyFlag),
		.resultValid   (resultValid),
		.resultData    (resultData),
		.offsetCoef    (offsetCoef),
		.gainCoef      (gainCoef),
		.dacTap        (dacTap),
		.dacRefSupply  (dacRefSupply)
	);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic testDone();
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : testDone
	task automatic doReset();
		rst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
	endtask : doReset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		@(negedge ref_clk);
		sfrWrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		@(negedge ref_clk);
		sfrRdEn = 1'b0;
		rdVal = sfrRdData;
	endtask : rd
	task automatic waitConv();
		while (convTick !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask : waitConv
	// Select 0 analog tick, 1 modulator tick, 2 conversion tick
	function automatic logic tick(input int sel);
		return (sel == 0) ? aclkTick : (sel == 1) ? modTick : convTick;
	endfunction : tick
	// Two ticks skipped, dividers may restart on write
	task automatic gap(input int sel, output int n);
		repeat (2) begin
			while (tick(sel) !== 1'b1) @(negedge ref_clk);
			@(negedge ref_clk);
		end
		n = 1;
		while (tick(sel) !== 1'b1) begin
			n++;
			@(negedge ref_clk);
		end
	endtask : gap
	task automatic tResetVals();
		rd(adc_ctrl_pkg::ADDR_SETUP);
		`CHK("setup", adc_ctrl_pkg::SETUP_RESET, rdVal)
		rd(adc_ctrl_pkg::ADDR_ACLK_DIV);
		`CHK("aclkDiv", adc_ctrl_pkg::ACLK_RESET, rdVal)
		rd(8'hE0);
		`CHK("unmapped", 8'h00, rdVal)
		`CHK("refBits", 3'h6, {refIntOn, refHigh, refExternal})
	endtask : tResetVals
	task automatic tSetup();
		logic [2:0] g;
		for (int i = 0; i < 8; i++) begin
			g = 3'(i);
			wr(adc_ctrl_pkg::ADDR_SETUP, {1'b0, g[0], g[1], 1'b1, g[2], g});
			`CHK("gain", g, gainSel)
			`CHK("buf", g[2], bufEnable)
			`CHK("ref", {g[1], g[0]}, {refHigh, refExternal})
		end
		wr(adc_ctrl_pkg::ADDR_SETUP, 8'h20);
		`CHK("refOff", 1'b0, refIntOn)
		wr(adc_ctrl_pkg::ADDR_SETUP, adc_ctrl_pkg::SETUP_RESET);
	endtask : tSetup
	task automatic tDac();
		logic [15:0] codes [4] = '{16'hFFFF, 16'h0000, 16'h8001, 16'h7FFE};
		for (int n = 0; n < 4; n++) begin
			wr(8'(adc_ctrl_pkg::ADDR_DAC_BASE + 2 * n), codes[n][7:0]);
			`CHK("staged", 16'h0000, dacTap[n])
			wr(8'(adc_ctrl_pkg::ADDR_DAC_BASE + 2 * n + 1), codes[n][15:8]);
			for (int k = 0; k < 4; k++)
				`CHK("dacTap", (k <= n) ? codes[k] : 16'h0000, dacTap[k])
		end
		wr(adc_ctrl_pkg::ADDR_DAC_REF, 8'h0A);
		`CHK("dac_reference_select", 4'hA, dacRefSupply)
	endtask : tDac
	task automatic tRate();
		int n;
		wr(adc_ctrl_pkg::ADDR_ACLK_DIV, 8'h01);
		wr(adc_ctrl_pkg::ADDR_DECIM, 8'h02);
		gap(0, n);
		`CHK("aclkPeriod", 2, n)
		gap(1, n);
		`CHK("modPeriod", 128, n)
		gap(2, n);
		`CHK("convPeriod", 256, n)
		wr(adc_ctrl_pkg::ADDR_ACLK_DIV, 8'h00);
		wr(adc_ctrl_pkg::ADDR_DECIM, 8'h01);
	endtask : tRate
	task automatic tCal(input logic [2:0] cmd, input int expN);
		int n;
		wr(adc_ctrl_pkg::ADDR_CALFILT, {5'h00, cmd});
		`CHK("calBusy", expN != 0, calBusy)
		`CHK("calSys", cmd[2] && expN != 0, calSysInput)
		n = 0;
		while (calBusy === 1'b1) begin
			n += int'(convTick === 1'b1);
			@(negedge ref_clk);
		end
		`CHK("calLen", expN, n)
		if (expN != 0)
			`CHK("ready", 1'b1, readyFlag)
		`CHK("calSysEnd", 1'b0, calSysInput)
		rd(adc_ctrl_pkg::ADDR_CALFILT);
		`CHK("cmdField", 3'h0, rdVal[2:0])
	endtask : tCal
	task automatic tOffset();
		filterSample = 24'h000123;
		tCal(3'h4, 7);
		`CHK("offsetCoef", 24'h000123, offsetCoef)
		filterSample = 24'h7FFFFF;
		tCal(3'h5, 7);
		`CHK("gainCoef", 24'h7FFEDC, gainCoef)
		wr(adc_ctrl_pkg::ADDR_TRIM, 8'hC5);
		`CHK("trim", 8'hC5, {trimSign, trimMag})
		filterSample = 24'h000130;
		waitConv();
		`CHK("valid", 1'b1, resultValid)
		`CHK("result", 24'h00000D, resultData)
	endtask : tOffset
	task automatic tFilter();
		int nf;
		int n2;
		nf = 0;
		n2 = 0;
		for (int f = 1; f < 4; f++) begin
			wr(adc_ctrl_pkg::ADDR_CALFILT, 8'(f << 4));
			waitConv();
			`CHK("filter", 2'(f), filterSel)
		end
		wr(adc_ctrl_pkg::ADDR_CALFILT, 8'h00);
		wr(adc_ctrl_pkg::ADDR_STATUS, 8'h01);
		channelChange = 1'b1;
		@(negedge ref_clk);
		channelChange = 1'b0;
		for (int k = 0; k < 5; k++) begin
			while (convTick !== 1'b1) @(negedge ref_clk);
			nf += int'(filterSel === 2'h1);
			n2 += int'(filterSel === 2'h2);
			if (k < 2)
				`CHK("discard", k == 0, discardConv)
			@(negedge ref_clk);
			if (k < 2)
				`CHK("readyAuto", k == 1, readyFlag)
		end
		`CHK("fastCount", 2, nf)
		`CHK("sinc2Count", 1, n2)
		`CHK("final", 2'h3, filterSel)
	endtask : tFilter
	task automatic tReset();
		`CHK("coefHeld", 24'h000123, offsetCoef)
		wr(adc_ctrl_pkg::ADDR_SETUP, 8'h73);
		doReset();
		@(negedge ref_clk);
		`CHK("gainAfterReset", 3'h0, gainSel)
		`CHK("refAfterReset", 3'h6, {refIntOn, refHigh, refExternal})
		`CHK("coefAfterReset", 24'h000000, offsetCoef)
	endtask : tReset
	initial begin
		rst_n = 1'b0;
		sfrAddr = 8'h00;
		sfrWrData = 8'h00;
		sfrWrEn = 1'b0;
		sfrRdEn = 1'b0;
		channelChange = 1'b0;
		filterSample = 24'h000000;
		numErrors = 0;
		numChecks = 0;
		doReset();
		tResetVals();
		tSetup();
		tDac();
		tRate();
		tCal(3'h1, 7);
		tCal(3'h2, 7);
		tCal(3'h3, 14);
		tCal(3'h6, 0);
		tOffset();
		tFilter();
		tReset();
		testDone();
	end
	// Whole run is near 4500 cycles
	initial begin
		#3000000;
		numErrors++;
		testDone();
	end
endmodule : adc_ctrl_tb
bind adc_ctrl adc_ctrl_props adc_ctrl_props_inst (
	.ref_clk      (ref_clk),
	.rst_n        (rst_n),
	.sfrAddr      (sfrAddr),
	.sfrWrEn      (sfrWrEn),
	.sfrWrData    (sfrWrData),
	.convTick     (convTick),
	.gainSel      (gainSel),
	.bufEnable    (bufEnable),
	.refIntOn     (refIntOn),
	.refHigh      (refHigh),
	.refExternal  (refExternal),
	.trimSign     (trimSign),
	.trimMag      (trimMag),
	.calBusy      (calBusy),
	.calSysInput  (calSysInput),
	.readyFlag    (readyFlag),
	.dacTap       (dacTap),
	.dacRefSupply (dacRefSupply)
);

// ---- verilog/adc_ctrl.sv ----
`timescale 1ns/1ps
// Function
// - Gain field selects 1 to 128
// - Trim held as sign plus magnitude
// - Trim limited to half selected range
// - Modulator tick is clock/(divider+1)/64
// - One result per decimation modulator periods
// - Three-bit command field starts calibration
// - Each calibration lasts seven conversions, the combined self command fourteen
// - System offset uses zero input
// - System gain uses full-scale input
// - Calibration end raises ready flag
// - Filter fast, sinc2 or sinc3
// - Auto mode steps fast, sinc2, sinc3
// - Reference internal or external, internal high
// - Internal level selectable, can be off
// - DAC takes 16-bit straight binary code
// - Code selects exactly one string tap
// - Each DAC picks own reference
// - Analog clock is clock/(divider+1)
// - Buffer bit switches input buffer
module adc_ctrl (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	input  wire logic [7:0]               sfrAddr,
	input  wire logic                     sfrWrEn,
	input  wire logic                     sfrRdEn,
	input  wire logic [7:0]               sfrWrData,
	output logic      [7:0]               sfrRdData,
	input  wire logic                     channelChange,
	input  wire logic [23:0]              filterSample,
	output logic      [2:0]               gainSel,
	output logic                          bufEnable,
	output logic                          refIntOn,
	output logic                          refHigh,
	output logic                          refExternal,
	output logic                          trimSign,
	output logic      [6:0]               trimMag,
	output logic                          aclkTick,
	output logic                          modTick,
	output logic                          convTick,
	output logic      [1:0]               filterSel,
	output logic                          discardConv,
	output logic                          calBusy,
	output logic                          calSysInput,
	output logic                          readyFlag,
	output logic                          resultValid,
	output logic      [23:0]              resultData,
	output logic      [23:0]              offsetCoef,
	output logic      [23:0]              gainCoef,
	output logic      [3:0][15:0]         dacTap,
	output logic      [3:0]               dacRefSupply
);

	typedef struct packed {
		logic [7:0]       setup;
		logic [7:0]       calFilt;
		logic [7:0]       trim;
		logic [7:0]       aclkDiv;
		logic [7:0]       decim;
		logic [7:0]       aclkCnt;
		logic [5:0]       modCnt;
		logic [7:0]       decCnt;
		logic             aclkTick;
		logic             modTick;
		logic             convTick;
		logic             calBusy;
		logic             calSys;
		logic             calGainNext;
		logic [2:0]       calKind;
		logic [3:0]       calCnt;
		logic [1:0]       autoStage;
		logic [1:0]       fastCnt;
		logic [1:0]       filterSel;
		logic             discard;
		logic             ready;
		logic             resValid;
		logic [23:0]      result;
		logic [23:0]      offsetCoef;
		logic [23:0]      gainCoef;
		logic [3:0][15:0] dacCode;
		logic [3:0][7:0]  dacLow;
		logic [3:0]       dac_reference_select;
		logic [7:0]       rdData;
	} adc_state_type;

	adc_state_type state_q;
	adc_state_type state_d;

	// Offset trim magnitude is the raw low seven bits, no saturation
	function automatic logic [6:0] trimLimit(input logic [7:0] raw);
		trimLimit = raw[6:0];
	endfunction : trimLimit

	function automatic logic isAddr(input logic [7:0] a, input logic [7:0] b);
		isAddr = (a == b);
	endfunction : isAddr

	logic       wrSetup;
	logic       wrCalFilt;
	logic       wrStatus;
	logic       calDone;
	logic       offsetStep;
	logic [2:0] dacIdx;
	logic [7:0] decLast;

	always_comb begin
		state_d = state_q;
		wrSetup   = sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_SETUP);
		wrCalFilt = sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_CALFILT);
		wrStatus  = sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_STATUS);
		calDone    = 1'b0;
		offsetStep = 1'b0;
		dacIdx     = 3'(sfrAddr[3:1]);
		// Ratio zero would stall results, treated as one
		decLast = (state_q.decim == 8'h00) ? 8'h00 : state_q.decim - 8'h01;
		state_d.aclkTick = 1'b0;
		state_d.modTick  = 1'b0;
		state_d.convTick = 1'b0;
		state_d.resValid = 1'b0;

		if (state_q.aclkCnt >= state_q.aclkDiv) begin
			state_d.aclkCnt  = 8'h00;
			state_d.aclkTick = 1'b1;
		end else begin
			state_d.aclkCnt = state_q.aclkCnt + 8'h01;
		end
		if (state_q.aclkTick) begin
			if (state_q.modCnt == adc_ctrl_pkg::MOD_DIV_LAST) begin
				state_d.modCnt  = 6'h00;
				state_d.modTick = 1'b1;
			end else begin
				state_d.modCnt = state_q.modCnt + 6'h01;
			end
		end
		if (state_q.modTick) begin
			if (state_q.decCnt >= decLast) begin
				state_d.decCnt   = 8'h00;
				state_d.convTick = 1'b1;
			end else begin
				state_d.decCnt = state_q.decCnt + 8'h01;
			end
		end

		// Conversion result handling
		if (state_q.convTick) begin
			if (state_q.calBusy) begin
				if (state_q.calCnt == 4'h1) begin
					offsetStep = !state_q.calGainNext;
					if (!state_q.calGainNext) begin
						state_d.offsetCoef = filterSample;
					end else begin
						state_d.gainCoef = filterSample - state_q.offsetCoef;
					end
					// Combined command runs gain after offset
					if (offsetStep && state_q.calKind == adc_ctrl_pkg::CAL_SELF_BOTH) begin
						state_d.calGainNext = 1'b1;
						state_d.calCnt      = adc_ctrl_pkg::CAL_CONV_COUNT;
					end else begin
						calDone = 1'b1;
					end
				end else begin
					state_d.calCnt = state_q.calCnt - 4'h1;
				end
			end else begin
				// Held offset applied to every result
				state_d.result = filterSample - state_q.offsetCoef;
				if (!state_q.discard) begin
					state_d.resValid = 1'b1;
					state_d.ready    = 1'b1;
				end
			end
			if (state_q.autoStage == 2'h0) begin
				if (state_q.fastCnt == 2'h1) begin
					state_d.autoStage = 2'h1;
				end else begin
					state_d.fastCnt = state_q.fastCnt + 2'h1;
				end
				state_d.discard = 1'b0;
			end else if (state_q.autoStage == 2'h1) begin
				state_d.autoStage = 2'h2;
			end
		end

		if (calDone) begin
			state_d.calBusy = 1'b0;
			state_d.calSys  = 1'b0;
			state_d.ready   = 1'b1;
			state_d.calFilt[adc_ctrl_pkg::CF_CAL_LSB +: 3] = 3'h0;
		end

		// Register writes
		if (wrSetup) begin
			state_d.setup = sfrWrData;
		end
		if (wrCalFilt) begin
			state_d.calFilt = sfrWrData;
			unique case (adc_ctrl_pkg::adc_cal_type'(sfrWrData[2:0]))
				adc_ctrl_pkg::CAL_SELF_OFS,
				adc_ctrl_pkg::CAL_SELF_GAIN,
				adc_ctrl_pkg::CAL_SELF_BOTH,
				adc_ctrl_pkg::CAL_SYS_OFS,
				adc_ctrl_pkg::CAL_SYS_GAIN: begin
					state_d.calBusy     = 1'b1;
					state_d.calKind     = sfrWrData[2:0];
					state_d.calCnt      = adc_ctrl_pkg::CAL_CONV_COUNT;
					state_d.calSys      = sfrWrData[2];
					state_d.calGainNext = (sfrWrData[2:0] == 3'(adc_ctrl_pkg::CAL_SELF_GAIN)) ||
						(sfrWrData[2:0] == 3'(adc_ctrl_pkg::CAL_SYS_GAIN));
					state_d.ready       = 1'b0;
				end
				default: begin
					state_d.calFilt[adc_ctrl_pkg::CF_CAL_LSB +: 3] = 3'h0;
				end
			endcase
		end
		// Ready cleared by writing one; a same-cycle set wins
		if (wrStatus && sfrWrData[adc_ctrl_pkg::ST_READY] && !calDone && !state_d.resValid) begin
			state_d.ready = 1'b0;
		end
		if (sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_TRIM)) begin
			state_d.trim = sfrWrData;
		end
		if (sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_ACLK_DIV)) begin
			state_d.aclkDiv = sfrWrData;
		end
		if (sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_DECIM)) begin
			state_d.decim = sfrWrData;
		end
		if (sfrWrEn && isAddr(sfrAddr, adc_ctrl_pkg::ADDR_DAC_REF)) begin
			state_d.dac_reference_select = sfrWrData[3:0];
		end
		if (sfrWrEn && sfrAddr[7:3] == adc_ctrl_pkg::ADDR_DAC_BASE[7:3]) begin
			if (!sfrAddr[0]) begin
				state_d.dacLow[dacIdx[1:0]] = sfrWrData;
			end else begin
				state_d.dacCode[dacIdx[1:0]] = {sfrWrData, state_q.dacLow[dacIdx[1:0]]};
			end
		end

		// Restart on channel or gain change
		if (channelChange || (wrSetup &&
			sfrWrData[adc_ctrl_pkg::SETUP_GAIN_LSB +: 3] !=
			state_q.setup[adc_ctrl_pkg::SETUP_GAIN_LSB +: 3])) begin
			state_d.autoStage = 2'h0;
			state_d.fastCnt   = 2'h0;
			state_d.discard   = 1'b1;
		end

		unique case (adc_ctrl_pkg::adc_filter_type'(state_d.calFilt[adc_ctrl_pkg::CF_FILT_LSB +: 2]))
			adc_ctrl_pkg::FILT_AUTO: begin
				state_d.filterSel = (state_d.autoStage == 2'h0) ? 2'(adc_ctrl_pkg::FILT_FAST) :
					(state_d.autoStage == 2'h1) ? 2'(adc_ctrl_pkg::FILT_SINC2) :
					2'(adc_ctrl_pkg::FILT_SINC3);
			end
			adc_ctrl_pkg::FILT_FAST:  state_d.filterSel = 2'(adc_ctrl_pkg::FILT_FAST);
			adc_ctrl_pkg::FILT_SINC2: state_d.filterSel = 2'(adc_ctrl_pkg::FILT_SINC2);
			adc_ctrl_pkg::FILT_SINC3: state_d.filterSel = 2'(adc_ctrl_pkg::FILT_SINC3);
		endcase
		if (state_d.calFilt[adc_ctrl_pkg::CF_FILT_LSB +: 2] != 2'(adc_ctrl_pkg::FILT_AUTO)) begin
			state_d.discard = 1'b0;
		end

		// Read port, undefined addresses read zero
		state_d.rdData = 8'h00;
		if (sfrRdEn) begin
			if (sfrAddr[7:3] == adc_ctrl_pkg::ADDR_DAC_BASE[7:3]) begin
				state_d.rdData = sfrAddr[0] ? state_q.dacCode[dacIdx[1:0]][15:8] :
					state_q.dacLow[dacIdx[1:0]];
			end else begin
				unique case (sfrAddr)
					adc_ctrl_pkg::ADDR_STATUS: state_d.rdData = {3'h0, state_q.discard,
						state_q.filterSel, state_q.calBusy, state_q.ready};
					adc_ctrl_pkg::ADDR_RES_LO:   state_d.rdData = state_q.result[7:0];
					adc_ctrl_pkg::ADDR_RES_MID:  state_d.rdData = state_q.result[15:8];
					adc_ctrl_pkg::ADDR_RES_HI:   state_d.rdData = state_q.result[23:16];
					adc_ctrl_pkg::ADDR_SETUP:    state_d.rdData = state_q.setup;
					adc_ctrl_pkg::ADDR_CALFILT:  state_d.rdData = state_q.calFilt;
					adc_ctrl_pkg::ADDR_DECIM:    state_d.rdData = state_q.decim;
					adc_ctrl_pkg::ADDR_TRIM:     state_d.rdData = state_q.trim;
					adc_ctrl_pkg::ADDR_DAC_REF:  state_d.rdData = {4'h0, state_q.dac_reference_select};
					adc_ctrl_pkg::ADDR_ACLK_DIV: state_d.rdData = state_q.aclkDiv;
					default:                     state_d.rdData = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q             <= '0;
			state_q.setup       <= adc_ctrl_pkg::SETUP_RESET;
			state_q.calFilt     <= adc_ctrl_pkg::CF_RESET;
			state_q.trim        <= adc_ctrl_pkg::TRIM_RESET;
			state_q.aclkDiv     <= adc_ctrl_pkg::ACLK_RESET;
			state_q.decim       <= adc_ctrl_pkg::DECIM_RESET;
			state_q.dacCode     <= {adc_ctrl_pkg::DAC_COUNT{adc_ctrl_pkg::DAC_RESET}};
			state_q.dac_reference_select      <= adc_ctrl_pkg::DAC_REF_RESET;
			state_q.autoStage   <= 2'h2;
			state_q.filterSel   <= 2'(adc_ctrl_pkg::FILT_SINC3);
		end else begin
			state_q <= state_d;
		end
	end

	assign sfrRdData    = state_q.rdData;
	assign gainSel      = state_q.setup[adc_ctrl_pkg::SETUP_GAIN_LSB +: 3];
	assign bufEnable    = state_q.setup[adc_ctrl_pkg::SETUP_BUF];
	assign refIntOn     = state_q.setup[adc_ctrl_pkg::SETUP_REF_ON];
	assign refHigh      = state_q.setup[adc_ctrl_pkg::SETUP_REF_HIGH];
	assign refExternal  = state_q.setup[adc_ctrl_pkg::SETUP_REF_EXT];
	assign trimSign     = state_q.trim[7];
	// Magnitude scaled to half of gain range in analog
	assign trimMag      = trimLimit(state_q.trim);
	assign aclkTick     = state_q.aclkTick;
	assign modTick      = state_q.modTick;
	assign convTick     = state_q.convTick;
	assign filterSel    = state_q.filterSel;
	assign discardConv  = state_q.discard;
	assign calBusy      = state_q.calBusy;
	assign calSysInput  = state_q.calSys;
	assign readyFlag    = state_q.ready;
	assign resultValid  = state_q.resValid;
	assign resultData   = state_q.result;
	assign offsetCoef   = state_q.offsetCoef;
	assign gainCoef     = state_q.gainCoef;
	// Index drives one switch of the string
	assign dacTap       = state_q.dacCode;
	assign dacRefSupply = state_q.dac_reference_select;

endmodule : adc_ctrl

// ---- verilog/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
	// Register addresses on the special function register port
	localparam logic [7:0] ADDR_STATUS    = 8'hD8;
	localparam logic [7:0] ADDR_RES_LO    = 8'hD9;
	localparam logic [7:0] ADDR_RES_MID   = 8'hDA;
	localparam logic [7:0] ADDR_RES_HI    = 8'hDB;
	localparam logic [7:0] ADDR_SETUP     = 8'hDC;
	localparam logic [7:0] ADDR_CALFILT   = 8'hDD;
	localparam logic [7:0] ADDR_DECIM     = 8'hDE;
	localparam logic [7:0] ADDR_TRIM      = 8'hE6;
	localparam logic [7:0] ADDR_DAC_BASE  = 8'hE8;
	localparam logic [7:0] ADDR_DAC_REF   = 8'hF0;
	localparam logic [7:0] ADDR_ACLK_DIV  = 8'hF6;
	// converter_setup fields
	localparam int SETUP_GAIN_LSB = 0;
	localparam int SETUP_BUF      = 3;
	localparam int SETUP_REF_ON   = 4;
	localparam int SETUP_REF_HIGH = 5;
	localparam int SETUP_REF_EXT  = 6;
	// Internal reference on at its higher level, unity gain
	localparam logic [7:0] SETUP_RESET = 8'h30;
	// calibration_filter_control fields
	localparam int CF_CAL_LSB  = 0;
	localparam int CF_FILT_LSB = 4;
	localparam logic [7:0] CF_RESET = 8'h00;
	// Status fields
	localparam int ST_READY = 0;
	localparam int ST_BUSY  = 1;
	localparam int ST_DISC  = 4;
	// Reset values
	localparam logic [7:0]  TRIM_RESET    = 8'h00;
	localparam logic [7:0]  ACLK_RESET    = 8'h00;
	localparam logic [7:0]  DECIM_RESET   = 8'h40;
	localparam logic [15:0] DAC_RESET     = 16'h0000;
	localparam logic [3:0]  DAC_REF_RESET = 4'h0;
	// Timing counts
	localparam logic [5:0] MOD_DIV_LAST   = 6'h3F;
	localparam logic [3:0] CAL_CONV_COUNT = 4'h7;
	localparam logic [1:0] FAST_CONV      = 2'h2;
	localparam int DAC_COUNT = 4;
	localparam int RES_WIDTH = 24;

	typedef enum logic [1:0] {
		FILT_AUTO,
		FILT_FAST,
		FILT_SINC2,
		FILT_SINC3
	} adc_filter_type;

	typedef enum logic [2:0] {
		CAL_NONE,
		CAL_SELF_OFS,
		CAL_SELF_GAIN,
		CAL_SELF_BOTH,
		CAL_SYS_OFS,
		CAL_SYS_GAIN,
		CAL_RSVD6,
		CAL_RSVD7
	} adc_cal_type;
endpackage : adc_ctrl_pkg
